// ---- design/stf_params.svh ----
// register offsets, field positions, reset values and event codes of the event filter
`ifndef STF_PARAMS_SVH
`define STF_PARAMS_SVH

`define STF_OFF_CTRL        8'h00
`define STF_OFF_XMASK       8'h04
`define STF_OFF_COUNT       8'h08
`define STF_OFF_STATUS      8'h0C

`define STF_CTRL_RST        32'h0000_0000
`define STF_XMASK_RST       32'h0000_0000

`define STF_EV_LOCAL_SNOOP  8'h5D
`define STF_EV_TRACK_INSERT 8'h35
`define STF_MAX_SLOT        3'h3

`define STF_XM_HIT          0
`define STF_XM_MISS         1
`define STF_XM_TGT_LSB      2
`define STF_XM_TGT_MSB      6
`define STF_XM_LOCAL_HOME   7
`define STF_XM_REMOTE_HOME  8
`define STF_XM_OPC_MATCH    9
`define STF_XM_ORIG_OPC     10
`define STF_XM_OPC_LSB      19
`define STF_XM_OPC_MSB      29

`define STF_UMASK_CORE      8'h01
`define STF_XM_CORE_ALL     32'h00C0_01FF
`define STF_XM_CORE_HIT     32'h00C0_01FD
`define STF_XM_CORE_MISS    32'h00C0_01FE
`define STF_XM_CRD_LOCAL    32'h00C8_0EFE
`define STF_XM_CRD_REMOTE   32'h00C8_0F7E
`define STF_XM_DRD_DRAM     32'h00C8_1786
`define STF_XM_DRD_PERSIST  32'h00C8_178A

`endif

// ---- design/stf_pkg.sv ----
// types shared by the snoop and tracker event filter
package stf_pkg;

	typedef enum logic [3:0] {
		RESP_I, RESP_S, RESP_IFWD, RESP_SFWD, RESP_IWB, RESP_SWB,
		RESP_FWDWB, RESP_CNFLCT, RESP_CNFLCT_WBI, RESP_FWD
	} stf_resp_t;

	typedef struct packed {
		logic      valid;
		logic      is_local;
		stf_resp_t rtype;
	} stf_snoop_t;

	// tgt one-hot: [0] dram, [1] persistent, [2] hbm, [3] mmcfg, [4] mmio
	typedef struct packed {
		logic        valid;
		logic        has_addr;
		logic [7:0]  src;
		logic        hit;
		logic        local_home;
		logic [4:0]  tgt;
		logic [10:0] opcode;
		logic [10:0] orig_opcode;
	} stf_insert_t;

	typedef struct packed {
		logic [11:0] rsvd;
		logic [2:0]  slot;
		logic        en;
		logic [7:0]  umask;
		logic [7:0]  code;
	} stf_ctrl_t;

	typedef enum {BUS_IDLE, BUS_WRITE} stf_bus_st_t;

endpackage : stf_pkg

// ---- design/stf_insert_qual.sv ----
// qualification of one tracking-table insertion against unit and extended masks
`timescale 1ns/1ps
`include "stf_params.svh"
module stf_insert_qual
	import stf_pkg::*;
(
	input  wire stf_insert_t i_ins,
	input  wire logic [7:0]  i_umask,
	input  wire logic [31:0] i_xmask,
	output logic             o_match
);
	logic        src_ok;
	logic        hm_ok;
	logic        tgt_ok;
	logic        home_ok;
	logic        opc_ok;
	logic [10:0] opc_sel;

	always_comb begin
		src_ok  = |(i_umask & i_ins.src);
		hm_ok   = i_ins.hit ? i_xmask[`STF_XM_HIT] : i_xmask[`STF_XM_MISS];
		tgt_ok  = |(i_ins.tgt & i_xmask[`STF_XM_TGT_MSB:`STF_XM_TGT_LSB]);
		home_ok = i_ins.local_home ? i_xmask[`STF_XM_LOCAL_HOME] : i_xmask[`STF_XM_REMOTE_HOME];
		// original opcode wins when both qualifiers are set
		opc_sel = i_xmask[`STF_XM_ORIG_OPC] ? i_ins.orig_opcode : i_ins.opcode;
		opc_ok  = 1'b1;
		if (i_xmask[`STF_XM_OPC_MATCH] || i_xmask[`STF_XM_ORIG_OPC]) begin
			opc_ok = (opc_sel == i_xmask[`STF_XM_OPC_MSB:`STF_XM_OPC_LSB]);
		end
		// address-less requests never qualify
		o_match = i_ins.valid && i_ins.has_addr && src_ok && hm_ok
			&& tgt_ok && home_ok && opc_ok;
	end

endmodule : stf_insert_qual

// ---- design/stf_top.sv ----
// snoop response and tracking-table insert event filter with counter, AHB-Lite slave
//
// Register access over AHB-Lite and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "stf_params.svh"
module stf_top
	import stf_pkg::*;
#(
	parameter int COUNT_W = 32
) (
	input  wire logic               i_core_clk,
	input  wire logic               i_reset,
	input  wire logic               i_clk_en,
	input  wire logic               i_hsel,
	input  wire logic [31:0]        i_haddr,
	input  wire logic [1:0]         i_htrans,
	input  wire logic               i_hwrite,
	input  wire logic [2:0]         i_hsize,
	input  wire logic [31:0]        i_hwdata,
	input  wire logic               i_hready,
	output logic [31:0]             o_hrdata,
	output logic                    o_hreadyout,
	output logic                    o_hresp,
	input  wire stf_snoop_t         i_snoop,
	input  wire stf_insert_t        i_insert,
	output logic [COUNT_W-1:0]      o_count,
	output logic                    o_inc
);

	if (COUNT_W < 1 || COUNT_W > 32) begin : g_bad_width
		$error("COUNT_W must lie in 1..32");
	end

	function automatic logic [2:0] resp_bit(input stf_resp_t r);
		case (r)
			RESP_I:          resp_bit = 3'h0;
			RESP_S:          resp_bit = 3'h1;
			RESP_IFWD:       resp_bit = 3'h2;
			RESP_SFWD:       resp_bit = 3'h3;
			RESP_IWB,
			RESP_SWB:        resp_bit = 3'h4;
			RESP_FWDWB:      resp_bit = 3'h5;
			RESP_CNFLCT,
			RESP_CNFLCT_WBI: resp_bit = 3'h6;
			RESP_FWD:        resp_bit = 3'h7;
			default:         resp_bit = 3'h0;
		endcase
	endfunction : resp_bit

	stf_ctrl_t          ctrl_r;
	stf_ctrl_t          ctrl_nxt;
	logic [31:0]        xmask_r;
	logic [31:0]        xmask_nxt;
	logic [COUNT_W-1:0] cnt_r;
	logic [COUNT_W-1:0] cnt_nxt;
	logic               inc_r;
	logic               inc_nxt;
	stf_bus_st_t        st_r;
	stf_bus_st_t        st_nxt;
	logic [7:0]         wr_addr_r;
	logic [7:0]         wr_addr_nxt;
	logic [31:0]        rdata_r;
	logic [31:0]        rdata_nxt;
	logic               ready_r;
	logic               resp_r;
	logic               ins_match;
	logic               slot_ok;
	logic               snoop_hit;
	logic               insert_hit;
	logic               addr_take;
	logic               cfg_ok;

	stf_insert_qual u_qual (
		.i_ins   (i_insert),
		.i_umask (ctrl_r.umask),
		.i_xmask (xmask_r),
		.o_match (ins_match)
	);

	// event selection and counting
	always_comb begin
		slot_ok    = (ctrl_r.slot <= `STF_MAX_SLOT);
		snoop_hit  = ctrl_r.en && slot_ok && (ctrl_r.code == `STF_EV_LOCAL_SNOOP)
			&& i_snoop.valid && i_snoop.is_local && ctrl_r.umask[resp_bit(i_snoop.rtype)];
		insert_hit = ctrl_r.en && slot_ok && (ctrl_r.code == `STF_EV_TRACK_INSERT)
			&& ins_match;
	end

	// bus decode and register update; a count write beats a same-cycle increment
	always_comb begin
		addr_take   = i_hsel && i_htrans[1] && i_hready;
		ctrl_nxt    = ctrl_r;
		xmask_nxt   = xmask_r;
		inc_nxt     = snoop_hit || insert_hit;
		cnt_nxt     = inc_nxt ? cnt_r + COUNT_W'(1) : cnt_r;
		if (st_r == BUS_WRITE) begin
			case (wr_addr_r)
				`STF_OFF_CTRL:  ctrl_nxt  = stf_ctrl_t'({12'h000, i_hwdata[19:0]});
				`STF_OFF_XMASK: xmask_nxt = i_hwdata;
				`STF_OFF_COUNT: cnt_nxt   = i_hwdata[COUNT_W-1:0];
				default: ;
			endcase
		end
		// back-to-back writes keep a write data phase pending
		case (st_r)
			BUS_IDLE,
			BUS_WRITE: st_nxt = (addr_take && i_hwrite) ? BUS_WRITE : BUS_IDLE;
			default:   st_nxt = BUS_IDLE;
		endcase
		wr_addr_nxt = addr_take ? i_haddr[7:0] : wr_addr_r;
		cfg_ok      = slot_ok && ((ctrl_r.code == `STF_EV_LOCAL_SNOOP)
			|| (ctrl_r.code == `STF_EV_TRACK_INSERT));
		// read control, mask and count from next values so a read right after a write sees the new word
		rdata_nxt   = 32'h0000_0000;
		if (addr_take && !i_hwrite) begin
			case (i_haddr[7:0])
				`STF_OFF_CTRL:   rdata_nxt = ctrl_nxt;
				`STF_OFF_XMASK:  rdata_nxt = xmask_nxt;
				`STF_OFF_COUNT:  rdata_nxt = 32'(cnt_nxt);
				`STF_OFF_STATUS: rdata_nxt = {29'h0, inc_r,
					ctrl_r.en && !cfg_ok, ctrl_r.en && cfg_ok};
				default:         rdata_nxt = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge i_core_clk or posedge i_reset) begin
		if (i_reset) begin
			ctrl_r    <= stf_ctrl_t'(`STF_CTRL_RST);
			xmask_r   <= `STF_XMASK_RST;
			cnt_r     <= '0;
			inc_r     <= 1'b0;
			st_r      <= BUS_IDLE;
			wr_addr_r <= 8'h00;
			rdata_r   <= 32'h0000_0000;
			ready_r   <= 1'b1;
			resp_r    <= 1'b0;
		end else if (i_clk_en) begin
			ctrl_r    <= ctrl_nxt;
			xmask_r   <= xmask_nxt;
			cnt_r     <= cnt_nxt;
			inc_r     <= inc_nxt;
			st_r      <= st_nxt;
			wr_addr_r <= wr_addr_nxt;
			rdata_r   <= rdata_nxt;
			ready_r   <= 1'b1;
			resp_r    <= 1'b0;
		end
	end

	// hresp sits in a flop like every other output, though it never leaves OKAY
	assign o_hrdata    = rdata_r;
	assign o_hreadyout = ready_r;
	assign o_hresp     = resp_r;
	assign o_count     = cnt_r;
	assign o_inc       = inc_r;

	// checks
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (i_reset);

	logic quiet;
	logic ins35;
	assign quiet = i_clk_en && !(st_r == BUS_WRITE && wr_addr_r == `STF_OFF_COUNT);
	assign ins35 = quiet && ctrl_r.code == `STF_EV_TRACK_INSERT && i_insert.valid;

	snoop_count_a: assert property (
		quiet && ctrl_r.en && slot_ok && ctrl_r.code == `STF_EV_LOCAL_SNOOP && i_snoop.valid
		&& i_snoop.is_local && ctrl_r.umask[resp_bit(i_snoop.rtype)]
		|=> cnt_r == COUNT_W'($past(cnt_r) + 1'b1) ##0 o_inc)
		else $error("matching snoop response did not add one");

	umask_gate_a: assert property (
		quiet && ctrl_r.code == `STF_EV_LOCAL_SNOOP
		&& !(i_snoop.valid && i_snoop.is_local && ctrl_r.umask[resp_bit(i_snoop.rtype)])
		|=> $stable(cnt_r))
		else $error("snoop response counted outside its unit mask");

	slot_limit_a: assert property (
		quiet && ctrl_r.slot > `STF_MAX_SLOT |=> $stable(cnt_r) && !o_inc)
		else $error("event counted on a counter above 3");

	addrless_a: assert property (
		ins35 && !i_insert.has_addr |=> $stable(cnt_r))
		else $error("address-less insertion counted");

	opc_match_a: assert property (
		ins35 && xmask_r[`STF_XM_OPC_MATCH] && !xmask_r[`STF_XM_ORIG_OPC]
		&& i_insert.opcode != xmask_r[`STF_XM_OPC_MSB:`STF_XM_OPC_LSB] |=> $stable(cnt_r))
		else $error("insertion with other opcode counted");

	orig_opc_a: assert property (
		ins35 && xmask_r[`STF_XM_ORIG_OPC]
		&& i_insert.orig_opcode != xmask_r[`STF_XM_OPC_MSB:`STF_XM_OPC_LSB] |=> $stable(cnt_r))
		else $error("insertion with other original opcode counted");

	core_all_a: assert property (
		ins35 && ctrl_r.en && slot_ok && ctrl_r.umask == `STF_UMASK_CORE
		&& xmask_r == `STF_XM_CORE_ALL && i_insert.has_addr && i_insert.src[0]
		&& i_insert.tgt != 5'h00 |=> cnt_r == COUNT_W'($past(cnt_r) + 1'b1))
		else $error("core insertion not counted under all-core preset");

	hit_miss_a: assert property (
		ins35 && ((xmask_r == `STF_XM_CORE_HIT && !i_insert.hit)
		|| (xmask_r == `STF_XM_CORE_MISS && i_insert.hit)) |=> $stable(cnt_r))
		else $error("hit or miss preset passed the wrong kind");

	home_a: assert property (
		ins35 && ((xmask_r == `STF_XM_CRD_LOCAL && !i_insert.local_home)
		|| (xmask_r == `STF_XM_CRD_REMOTE && i_insert.local_home)) |=> $stable(cnt_r))
		else $error("home preset passed the wrong home");

	mem_type_a: assert property (
		ins35 && ((xmask_r == `STF_XM_DRD_DRAM && !i_insert.tgt[0])
		|| (xmask_r == `STF_XM_DRD_PERSIST && !i_insert.tgt[1])) |=> $stable(cnt_r))
		else $error("memory type preset passed the wrong target");

	insert_count_a: assert property (
		quiet && insert_hit |=> cnt_r == COUNT_W'($past(cnt_r) + 1'b1) ##0 o_inc)
		else $error("qualifying insertion did not add one");

	inc_pulse_a: assert property (
		i_clk_en && !snoop_hit && !insert_hit |=> !o_inc)
		else $error("increment pulse without a counted event");

	disabled_a: assert property (
		quiet && !ctrl_r.en |=> $stable(cnt_r) && !o_inc)
		else $error("event counted while counting is disabled");

	other_code_a: assert property (
		quiet && ctrl_r.code != `STF_EV_LOCAL_SNOOP && ctrl_r.code != `STF_EV_TRACK_INSERT
		|=> $stable(cnt_r) && !o_inc)
		else $error("event counted under an unknown event code");

	remote_snoop_a: assert property (
		quiet && ctrl_r.code == `STF_EV_LOCAL_SNOOP && i_snoop.valid && !i_snoop.is_local
		|=> $stable(cnt_r))
		else $error("snoop response to a remote request counted");

	// one check per unit-mask bit, so a crossed bit index shows up on its own
	for (genvar b = 0; b < 8; b++) begin : g_umask_chk
		umask_bit_a: assert property (
			quiet && ctrl_r.en && slot_ok && ctrl_r.code == `STF_EV_LOCAL_SNOOP
			&& i_snoop.valid && i_snoop.is_local && resp_bit(i_snoop.rtype) == 3'(b)
			|=> ($past(ctrl_r.umask[b])
			? (cnt_r == COUNT_W'($past(cnt_r) + 1'b1)) : $stable(cnt_r)))
			else $error("snoop response counted against its unit-mask bit");
	end

	// with the enable low nothing may move, bus state included
	freeze_a: assert property (
		!i_clk_en |=> $stable(cnt_r) && $stable(ctrl_r) && $stable(xmask_r)
		&& $stable(st_r) && $stable(o_hrdata) && $stable(o_inc))
		else $error("state moved while the clock enable was low");

	// register writes land at the edge that closes the data phase
	count_load_a: assert property (
		i_clk_en && st_r == BUS_WRITE && wr_addr_r == `STF_OFF_COUNT
		|=> cnt_r == $past(i_hwdata[COUNT_W-1:0]))
		else $error("count write did not load the counter");

	ctrl_load_a: assert property (
		i_clk_en && st_r == BUS_WRITE && wr_addr_r == `STF_OFF_CTRL
		|=> ctrl_r == stf_ctrl_t'({12'h000, $past(i_hwdata[19:0])}))
		else $error("control write did not land");

	xmask_load_a: assert property (
		i_clk_en && st_r == BUS_WRITE && wr_addr_r == `STF_OFF_XMASK
		|=> xmask_r == $past(i_hwdata))
		else $error("extended mask write did not land");

	// a stale word would pass for data with a master that samples late
	rdata_idle_a: assert property (
		i_clk_en && !(addr_take && !i_hwrite) |=> o_hrdata == 32'h0000_0000)
		else $error("read data shown outside a read data phase");

	status_a: assert property (
		i_clk_en && addr_take && !i_hwrite && i_haddr[7:0] == `STF_OFF_STATUS
		|=> o_hrdata[31:3] == 29'h0 && !(o_hrdata[1] && o_hrdata[0]))
		else $error("status word has reserved or conflicting bits set");

	bus_okay_a: assert property (o_hreadyout && !o_hresp)
		else $error("slave stalled or answered with an error");

	snoop_seen_c:  cover property (snoop_hit ##1 o_inc);
	insert_seen_c: cover property (insert_hit && xmask_r == `STF_XM_CORE_MISS);
	bad_slot_c:    cover property (ctrl_r.en && ctrl_r.slot > `STF_MAX_SLOT);
	wr_rd_c:       cover property (st_r == BUS_WRITE && addr_take && !i_hwrite);
	count_wrap_c:  cover property (insert_hit && cnt_r == '1);

endmodule : stf_top

// ---- testbench/stf_top_bench.sv ----
// self-checking bench for the snoop response and tracker insert event filter
`timescale 1ns/1ps
`include "stf_params.svh"
module stf_top_bench
	import stf_pkg::*;
;
	logic        i_core_clk = 0;
	logic        i_reset    = 1;
	logic        i_clk_en   = 1;
	logic        i_hsel     = 0;
	logic        i_hwrite   = 0;
	logic [1:0]  i_htrans   = 2'h0;
	logic [2:0]  i_hsize    = 3'h2;
	logic [31:0] i_haddr    = 32'h0;
	logic [31:0] i_hwdata   = 32'h0;
	stf_snoop_t  i_snoop    = '0;
	stf_insert_t i_insert   = '0;
	wire logic   i_hready;
	logic [31:0] o_hrdata;
	logic [31:0] o_count;
	logic        o_hreadyout;
	logic        o_hresp;
	logic        o_inc;
	logic [31:0] exp_cnt = 32'h0;
	logic [31:0] ctrl    = 32'h0;
	logic [31:0] xm      = 32'h0;
	logic [31:0] rd;
	logic        exp_inc = 0;
	int          fails = 0;
	int          compares = 0;
	int          cyc = 0;
	int          rmap[10] = '{0, 1, 2, 3, 4, 4, 5, 6, 6, 7};

	// single slave, so its ready is the bus ready
	assign i_hready = o_hreadyout;

	stf_top #(.COUNT_W(32)) dut (
		.i_core_clk(i_core_clk), .i_reset(i_reset), .i_clk_en(i_clk_en),
		.i_hsel(i_hsel), .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite),
		.i_hsize(i_hsize), .i_hwdata(i_hwdata), .i_hready(i_hready),
		.o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp),
		.i_snoop(i_snoop), .i_insert(i_insert), .o_count(o_count), .o_inc(o_inc)
	);

	always #5 i_core_clk = ~i_core_clk;

	always @(posedge i_core_clk) begin
		cyc++;
		if (cyc > 20000) begin
			fails++;
			wrap_up();
		end
	end

	task automatic chk(string nm, logic [31:0] e, logic [31:0] s);
		compares++;
		if (s !== e) begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", nm, e, s);
		end
	endtask : chk

	task automatic bus(logic [31:0] a, logic w, logic [31:0] d, output logic [31:0] q);
		@(posedge i_core_clk);
		i_hsel   <= 1;
		i_htrans <= 2'h2;
		i_haddr  <= a;
		i_hwrite <= w;
		do @(posedge i_core_clk); while (i_hready !== 1'b1);
		i_htrans <= 2'h0;
		i_hsel   <= 0;
		i_hwdata <= d;
		// read word stands in the data phase and is taken at its closing edge
		do @(posedge i_core_clk); while (i_hready !== 1'b1);
		q = o_hrdata;
		chk("hresp", 32'h0, 32'(o_hresp));
	endtask : bus

	// reference count rule, kept apart from the design's own qualifier
	function automatic int hit(logic [31:0] c, logic [31:0] x, stf_snoop_t s, stf_insert_t n);
		if (!c[16] || c[19:17] > 3'h3) return 0;
		if (c[7:0] == `STF_EV_LOCAL_SNOOP && s.valid && s.is_local)
			return int'(c[8 + rmap[int'(s.rtype)]]);
		if (c[7:0] == `STF_EV_TRACK_INSERT && n.valid && n.has_addr && |(c[15:8] & n.src)
			&& (n.hit ? x[0] : x[1]) && |(n.tgt & x[6:2]) && (n.local_home ? x[7] : x[8])
			&& (!(x[9] | x[10]) || (x[10] ? n.orig_opcode : n.opcode) == x[29:19]))
			return 1;
		return 0;
	endfunction : hit

	task automatic run(int n);
		stf_snoop_t  s;
		stf_insert_t t;
		logic        ce;
		int          m;
		for (int k = 0; k < n + 2; k++) begin
			@(posedge i_core_clk);
			s = '{valid: k < n && $urandom % 4 != 0, is_local: 1'($urandom),
				rtype: stf_resp_t'($urandom % 10)};
			t = '0;
			t.valid = k < n && $urandom % 2;
			t.has_addr = $urandom % 4 != 0;
			t.src = 8'($urandom);
			t.hit = 1'($urandom);
			t.local_home = 1'($urandom);
			t.tgt = ($urandom % 6 == 5) ? 5'h0 : 5'h1 << ($urandom % 5);
			t.opcode = ($urandom % 2) ? xm[29:19] : 11'($urandom);
			t.orig_opcode = ($urandom % 2) ? xm[29:19] : 11'($urandom);
			// clock enable dropped now and then: flops must freeze
			ce = k >= n || $urandom % 8 != 0;
			i_snoop  <= s;
			i_insert <= t;
			i_clk_en <= ce;
			m = hit(ctrl, xm, s, t);
			#1;
			chk("count", exp_cnt, o_count);
			chk("inc", 32'(exp_inc), 32'(o_inc));
			if (ce) begin
				exp_cnt += 32'(m);
				exp_inc = m[0];
			end
		end
	endtask : run

	task automatic test(string nm, logic [31:0] c, logic [31:0] x);
		logic ok;
		ctrl = c;
		xm = x;
		bus(32'(`STF_OFF_XMASK), 1, x, rd);
		bus(32'(`STF_OFF_CTRL), 1, c, rd);
		bus(32'(`STF_OFF_CTRL), 0, 32'h0, rd);
		chk("ctrl", c & 32'h000F_FFFF, rd);
		bus(32'(`STF_OFF_XMASK), 0, 32'h0, rd);
		chk("xmask", x, rd);
		run(150);
		bus(32'(`STF_OFF_COUNT), 0, 32'h0, rd);
		chk("count read", exp_cnt, rd);
		ok = c[19:17] <= 3'h3
			&& (c[7:0] == `STF_EV_LOCAL_SNOOP || c[7:0] == `STF_EV_TRACK_INSERT);
		bus(32'(`STF_OFF_STATUS), 0, 32'h0, rd);
		chk("status", {29'h0, 1'b0, c[16] && !ok, c[16] && ok}, rd);
		$display("test %s done", nm);
	endtask : test

	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", compares, fails);
		if (fails == 0 && compares > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : wrap_up

	initial begin
		logic [31:0] pre[7];
		pre = '{`STF_XM_CORE_ALL, `STF_XM_CORE_HIT, `STF_XM_CORE_MISS, `STF_XM_CRD_LOCAL,
			`STF_XM_CRD_REMOTE, `STF_XM_DRD_DRAM, `STF_XM_DRD_PERSIST};
		void'($urandom(32'h4FF7));
		repeat (16) @(posedge i_core_clk);
		i_reset <= 0;
		for (int a = 0; a < 5; a++) begin
			bus(32'(a * 4 + 4 * (a / 4)), 0, 32'h0, rd);
			chk("reset read", 32'h0, rd);
		end
		bus(32'h10, 1, 32'hFFFF_FFFF, rd);
		bus(32'h10, 0, 32'h0, rd);
		chk("unmapped", 32'h0, rd);
		$display("test reset done");
		for (int b = 0; b < 8; b++)
			test("snoop", {12'h0, 3'($urandom % 4), 1'b1, 8'h1 << b, `STF_EV_LOCAL_SNOOP}, 0);
		test("bad slot", {12'h0, 3'h4, 1'b1, 8'hFF, `STF_EV_LOCAL_SNOOP}, 0);
		test("bad code", {12'h0, 3'h0, 1'b1, 8'hFF, 8'h5C}, 0);
		test("disabled", {12'h0, 3'h1, 1'b0, 8'hFF, `STF_EV_TRACK_INSERT}, pre[0]);
		// preload near the top so the insert runs wrap the counter
		bus(32'(`STF_OFF_COUNT), 1, 32'hFFFF_FFF0, rd);
		exp_cnt = 32'hFFFF_FFF0;
		foreach (pre[i])
			test("preset", {12'h0, 3'($urandom % 4), 1'b1, `STF_UMASK_CORE,
				`STF_EV_TRACK_INSERT}, pre[i]);
		for (int q = 0; q < 3; q++)
			test("opcode", {12'h0, 3'h3, 1'b1, 8'($urandom), `STF_EV_TRACK_INSERT},
				pre[0] | 32'(q + 1) << 9 | 32'($urandom % 2048) << 19);
		wrap_up();
	end
endmodule : stf_top_bench
